// >>> pkg/drsc_pkg.sv
// Purpose: shared constants for the drive source configuration register bank
// Assumes: register indices are word indices; byte address is four times the index
// Notes:   codes and limits are held here once and used by name in hdl/
`default_nettype none

package drsc_pkg;

  localparam int unsigned DATA_W  = 16;
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned IDX_W   = 14;
  localparam int unsigned MOTORS  = 3;

  // register indices
  localparam logic [IDX_W-1:0] IDX_SETPOINT_HI = 14'h0001;
  localparam logic [IDX_W-1:0] IDX_SETPOINT_LO = 14'h0002;
  localparam logic [IDX_W-1:0] IDX_STATUS      = 14'h0100;
  localparam logic [IDX_W-1:0] IDX_FREQ_SRC    = 14'h1201;
  localparam logic [IDX_W-1:0] IDX_RUN_SRC     = 14'h1202;
  localparam logic [IDX_W-1:0] IDX_BASE_M1     = 14'h1203;
  localparam logic [IDX_W-1:0] IDX_MAX_M1      = 14'h1204;
  localparam logic [IDX_W-1:0] IDX_TOGGLE_SEL  = 14'h1205;
  localparam logic [IDX_W-1:0] IDX_COMBINE     = 14'h1206;
  localparam logic [IDX_W-1:0] IDX_BASE_M2     = 14'h2203;
  localparam logic [IDX_W-1:0] IDX_MAX_M2      = 14'h2204;
  localparam logic [IDX_W-1:0] IDX_BASE_M3     = 14'h3203;
  localparam logic [IDX_W-1:0] IDX_MAX_M3      = 14'h3204;
  localparam logic [IDX_W-1:0] IDX_MOTOR_STEP  = 14'h1000;

  // frequency source codes
  localparam logic [DATA_W-1:0] FSRC_KEYPAD_POT = 16'h0000;
  localparam logic [DATA_W-1:0] FSRC_TERMINAL   = 16'h0001;
  localparam logic [DATA_W-1:0] FSRC_SETPOINT   = 16'h0002;
  localparam logic [DATA_W-1:0] FSRC_SEQUENCE   = 16'h0007;
  localparam logic [DATA_W-1:0] FSRC_CALC       = 16'h000a;

  // run source codes
  localparam logic [DATA_W-1:0] RSRC_MIN = 16'h0001;
  localparam logic [DATA_W-1:0] RSRC_MAX = 16'h0005;

  // analog toggle and bipolar combine codes
  localparam logic [DATA_W-1:0] TOGGLE_MAX      = 16'h0004;
  localparam logic [DATA_W-1:0] COMB_NONE       = 16'h0000;
  localparam logic [DATA_W-1:0] COMB_SUM_NO_REV = 16'h0001;
  localparam logic [DATA_W-1:0] COMB_SUM_REV    = 16'h0002;
  localparam logic [DATA_W-1:0] COMB_O2_OFF     = 16'h0003;

  // frequency limits in whole hertz
  localparam logic [DATA_W-1:0] FREQ_MIN_HZ = 16'h001e;
  localparam logic [DATA_W-1:0] FREQ_MAX_HZ = 16'h0190;

  // stored target frequency, 0.01 Hz units
  localparam logic [2*DATA_W-1:0] SETPOINT_MAX = 32'h00009c40;

  // reset values
  localparam logic [DATA_W-1:0]   RST_FREQ_SRC = FSRC_TERMINAL;
  localparam logic [DATA_W-1:0]   RST_RUN_SRC  = RSRC_MIN;
  localparam logic [DATA_W-1:0]   RST_BASE_HZ  = 16'h003c;
  localparam logic [DATA_W-1:0]   RST_MAX_HZ   = 16'h003c;
  localparam logic [DATA_W-1:0]   RST_TOGGLE   = 16'h0000;
  localparam logic [DATA_W-1:0]   RST_COMBINE  = COMB_NONE;
  localparam logic [2*DATA_W-1:0] RST_SETPOINT = 32'h00000000;

  // status bit positions
  localparam int unsigned ST_REJECT_BIT   = 0;
  localparam int unsigned ST_SETPOINT_BIT = 1;

endpackage : drsc_pkg

`default_nettype wire

// >>> hdl/drsc_motor_freq.sv
// Purpose: base and maximum frequency pair for one motor
// Assumes: write strobes are one-cycle pulses at the completing bus edge
// Notes:   a write outside its range leaves the stored value untouched
`default_nettype none

module drsc_motor_freq
  import drsc_pkg::*;
#(
  parameter logic [DATA_W-1:0] BASE_RST = RST_BASE_HZ,
  parameter logic [DATA_W-1:0] MAX_RST  = RST_MAX_HZ
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // write side
  input  wire logic              wr_base,
  input  wire logic              wr_max,
  input  wire logic [DATA_W-1:0] wdata,
  // state
  output logic                   base_ok,
  output logic                   max_ok,
  output logic      [DATA_W-1:0] base_q,
  output logic      [DATA_W-1:0] max_q
);

  logic [DATA_W-1:0] base_d;
  logic [DATA_W-1:0] max_d;

  always_comb begin
    // base stays at or below this motor's own maximum
    base_ok = (wdata >= FREQ_MIN_HZ) && (wdata <= max_q);
    // a maximum below the stored base would break the base limit
    max_ok  = (wdata >= FREQ_MIN_HZ) && (wdata <= FREQ_MAX_HZ)
              && (wdata >= base_q);
    base_d  = (wr_base && base_ok) ? wdata : base_q;
    max_d   = (wr_max && max_ok) ? wdata : max_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q <= BASE_RST;
      max_q  <= MAX_RST;
    end else begin
      base_q <= base_d;
      max_q  <= max_d;
    end
  end

endmodule : drsc_motor_freq

`default_nettype wire

// >>> hdl/drsc_regs.sv
// Purpose: APB slave holding the drive source configuration bank
// Assumes: single clock; APB master keeps the request stable until pready
// Notes:   every access waits one cycle in the access phase before pready
//
// Design decision made here: the APB interface to the registers.
`default_nettype none

module drsc_regs
  import drsc_pkg::*;
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic      [31:0]         prdata,
  output logic                     pslverr,
  // source selections
  output logic      [DATA_W-1:0]   freq_source_select,
  output logic      [DATA_W-1:0]   run_source_select,
  output logic      [DATA_W-1:0]   analog_toggle_select,
  output logic      [DATA_W-1:0]   bipolar_input_combine,
  // decoded analog combine controls
  output logic                     sum_inputs_en,
  output logic                     reverse_sum_allowed,
  output logic                     bipolar_voltage_input_off,
  // stored target frequency
  output logic                     setpoint_active,
  output logic      [2*DATA_W-1:0] stored_target_frequency,
  // per motor frequency limits
  output logic      [DATA_W-1:0]   base_freq_motor1,
  output logic      [DATA_W-1:0]   max_freq_motor1,
  output logic      [DATA_W-1:0]   base_freq_motor2,
  output logic      [DATA_W-1:0]   max_freq_motor2,
  output logic      [DATA_W-1:0]   base_freq_motor3,
  output logic      [DATA_W-1:0]   max_freq_motor3
);

  // bus decode
  logic              ready_q;
  logic              ready_d;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;
  logic              slverr_q;
  logic              slverr_d;
  logic              commit;
  logic [IDX_W-1:0]  idx;
  logic [DATA_W-1:0] wdata;
  logic              aligned;

  assign commit  = psel && penable && ready_q;
  assign idx     = paddr[ADDR_W-1:2];
  assign wdata   = pwdata[DATA_W-1:0];
  assign aligned = (paddr[1:0] == 2'b00);

  // stored regs
  logic [DATA_W-1:0]   fsrc_q;
  logic [DATA_W-1:0]   fsrc_d;
  logic [DATA_W-1:0]   rsrc_q;
  logic [DATA_W-1:0]   rsrc_d;
  logic [DATA_W-1:0]   tog_q;
  logic [DATA_W-1:0]   tog_d;
  logic [DATA_W-1:0]   comb_q;
  logic [DATA_W-1:0]   comb_d;
  logic [2*DATA_W-1:0] setp_q;
  logic [2*DATA_W-1:0] setp_d;
  logic                reject_q;
  logic                reject_d;
  logic                sum_en_q;
  logic                sum_en_d;
  logic                rev_ok_q;
  logic                rev_ok_d;
  logic                o2_off_q;
  logic                o2_off_d;
  logic                setp_act_q;
  logic                setp_act_d;

  // motor copies
  logic [MOTORS-1:0]   wr_base;
  logic [MOTORS-1:0]   wr_max;
  logic [MOTORS-1:0]   base_ok;
  logic [MOTORS-1:0]   max_ok;
  logic [DATA_W-1:0]   base_q [MOTORS];
  logic [DATA_W-1:0]   max_q  [MOTORS];

  genvar gm;
  generate
    for (gm = 0; gm < MOTORS; gm++) begin : g_motor
      localparam logic [IDX_W-1:0] BASE_IDX = IDX_BASE_M1 + IDX_W'(gm) * IDX_MOTOR_STEP;
      localparam logic [IDX_W-1:0] MAX_IDX  = IDX_MAX_M1 + IDX_W'(gm) * IDX_MOTOR_STEP;
      assign wr_base[gm] = commit && pwrite && aligned && (idx == BASE_IDX);
      assign wr_max[gm]  = commit && pwrite && aligned && (idx == MAX_IDX);
      drsc_motor_freq u_freq (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_base (wr_base[gm]),
        .wr_max  (wr_max[gm]),
        .wdata   (wdata),
        .base_ok (base_ok[gm]),
        .max_ok  (max_ok[gm]),
        .base_q  (base_q[gm]),
        .max_q   (max_q[gm])
      );
    end
  endgenerate

  // range checks
  function automatic logic fsrc_valid(input logic [DATA_W-1:0] v);
    fsrc_valid = (v <= FSRC_SEQUENCE) || (v == FSRC_CALC);
  endfunction : fsrc_valid

  logic              hit;
  logic              in_range;
  logic [DATA_W-1:0] rd_val;
  logic [2*DATA_W-1:0] setp_hi_new;
  logic [2*DATA_W-1:0] setp_lo_new;

  assign setp_hi_new = {wdata, setp_q[DATA_W-1:0]};
  assign setp_lo_new = {setp_q[2*DATA_W-1:DATA_W], wdata};

  // hit, range and readback for the addressed word
  always_comb begin
    hit      = aligned;
    in_range = 1'b1;
    rd_val   = '0;
    case (idx)
      IDX_SETPOINT_HI: begin
        rd_val   = setp_q[2*DATA_W-1:DATA_W];
        in_range = (setp_hi_new <= SETPOINT_MAX);
      end
      IDX_SETPOINT_LO: begin
        rd_val   = setp_q[DATA_W-1:0];
        in_range = (setp_lo_new <= SETPOINT_MAX);
      end
      IDX_STATUS: begin
        rd_val[ST_REJECT_BIT]   = reject_q;
        rd_val[ST_SETPOINT_BIT] = setp_act_q;
        in_range                = 1'b0;
      end
      IDX_FREQ_SRC: begin
        rd_val   = fsrc_q;
        in_range = fsrc_valid(wdata);
      end
      IDX_RUN_SRC: begin
        rd_val   = rsrc_q;
        in_range = (wdata >= RSRC_MIN) && (wdata <= RSRC_MAX);
      end
      IDX_TOGGLE_SEL: begin
        rd_val   = tog_q;
        in_range = (wdata <= TOGGLE_MAX);
      end
      IDX_COMBINE: begin
        rd_val   = comb_q;
        in_range = (wdata <= COMB_O2_OFF);
      end
      IDX_BASE_M1: begin
        rd_val   = base_q[0];
        in_range = base_ok[0];
      end
      IDX_MAX_M1: begin
        rd_val   = max_q[0];
        in_range = max_ok[0];
      end
      IDX_BASE_M2: begin
        rd_val   = base_q[1];
        in_range = base_ok[1];
      end
      IDX_MAX_M2: begin
        rd_val   = max_q[1];
        in_range = max_ok[1];
      end
      IDX_BASE_M3: begin
        rd_val   = base_q[2];
        in_range = base_ok[2];
      end
      IDX_MAX_M3: begin
        rd_val   = max_q[2];
        in_range = max_ok[2];
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // bus answer
  always_comb begin
    // one wait cycle, then ready for exactly one edge
    ready_d  = psel && penable && !ready_q;
    rdata_d  = rdata_q;
    slverr_d = 1'b0;
    if (ready_d) begin
      rdata_d  = (hit && !pwrite) ? {{(32-DATA_W){1'b0}}, rd_val} : 32'h00000000;
      // unmapped or reserved words, and refused writes, answer with an error
      slverr_d = !hit || (pwrite && !in_range);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q  <= 1'b0;
      rdata_q  <= 32'h00000000;
      slverr_q <= 1'b0;
    end else begin
      ready_q  <= ready_d;
      rdata_q  <= rdata_d;
      slverr_q <= slverr_d;
    end
  end

  // register update
  logic wr_ok;
  assign wr_ok = commit && pwrite && hit && in_range;

  always_comb begin
    fsrc_d   = fsrc_q;
    rsrc_d   = rsrc_q;
    tog_d    = tog_q;
    comb_d   = comb_q;
    setp_d   = setp_q;
    reject_d = reject_q;
    if (commit && pwrite) begin
      // tracks the most recent write only
      reject_d = !(hit && in_range);
    end
    if (wr_ok) begin
      case (idx)
        IDX_FREQ_SRC:    fsrc_d = wdata;
        IDX_RUN_SRC:     rsrc_d = wdata;
        IDX_TOGGLE_SEL:  tog_d  = wdata;
        IDX_COMBINE:     comb_d = wdata;
        IDX_SETPOINT_HI: setp_d = setp_hi_new;
        IDX_SETPOINT_LO: setp_d = setp_lo_new;
        default:         fsrc_d = fsrc_q;
      endcase
    end
    // decoded controls follow the next stored codes
    sum_en_d   = (comb_d == COMB_SUM_NO_REV) || (comb_d == COMB_SUM_REV);
    rev_ok_d   = (comb_d == COMB_SUM_REV);
    o2_off_d   = (comb_d == COMB_O2_OFF);
    setp_act_d = (fsrc_d == FSRC_SETPOINT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsrc_q     <= RST_FREQ_SRC;
      rsrc_q     <= RST_RUN_SRC;
      tog_q      <= RST_TOGGLE;
      comb_q     <= RST_COMBINE;
      setp_q     <= RST_SETPOINT;
      reject_q   <= 1'b0;
      sum_en_q   <= 1'b0;
      rev_ok_q   <= 1'b0;
      o2_off_q   <= 1'b0;
      setp_act_q <= 1'b0;
    end else begin
      fsrc_q     <= fsrc_d;
      rsrc_q     <= rsrc_d;
      tog_q      <= tog_d;
      comb_q     <= comb_d;
      setp_q     <= setp_d;
      reject_q   <= reject_d;
      sum_en_q   <= sum_en_d;
      rev_ok_q   <= rev_ok_d;
      o2_off_q   <= o2_off_d;
      setp_act_q <= setp_act_d;
    end
  end

  // outputs
  assign pready                    = ready_q;
  assign prdata                    = rdata_q;
  assign pslverr                   = slverr_q;
  assign freq_source_select        = fsrc_q;
  assign run_source_select         = rsrc_q;
  assign analog_toggle_select      = tog_q;
  assign bipolar_input_combine     = comb_q;
  assign sum_inputs_en             = sum_en_q;
  assign reverse_sum_allowed       = rev_ok_q;
  assign bipolar_voltage_input_off = o2_off_q;
  assign setpoint_active           = setp_act_q;
  assign stored_target_frequency   = setp_q;
  assign base_freq_motor1          = base_q[0];
  assign max_freq_motor1           = max_q[0];
  assign base_freq_motor2          = base_q[1];
  assign max_freq_motor2           = max_q[1];
  assign base_freq_motor3          = base_q[2];
  assign max_freq_motor3           = max_q[2];

endmodule : drsc_regs

`default_nettype wire

// >>> tb/drsc_regs_properties.sv
// Purpose: port checks for the drive source register bank
// Assumes: apb master holds each request until pready
// Notes:   only motor one limits are watched here
`default_nettype none

module drsc_regs_properties
  import drsc_pkg::*;
(
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // settings
  input wire logic [DATA_W-1:0] freq_source_select,
  input wire logic [DATA_W-1:0] bipolar_input_combine,
  input wire logic              sum_inputs_en,
  input wire logic              reverse_sum_allowed,
  input wire logic              bipolar_voltage_input_off,
  input wire logic              setpoint_active,
  input wire logic [DATA_W-1:0] base_freq_motor1,
  input wire logic [DATA_W-1:0] max_freq_motor1
);
  logic [DATA_W-1:0] cmb;
  assign cmb = bipolar_input_combine;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_done; psel && penable && pready; endsequence
  sequence s_fw; s_done ##0 (pwrite && paddr == {IDX_FREQ_SRC, 2'b00}); endsequence
  property p_wait; s_wait |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_taken; s_fw ##0 !pslverr |=> freq_source_select == $past(pwdata[15:0]); endproperty
  a_taken: assert property (p_taken) else $error("source not stored");
  property p_kept; s_fw ##0 pslverr |=> $stable(freq_source_select); endproperty
  a_kept: assert property (p_kept) else $error("refused write changed source");
  property p_codes; freq_source_select <= 16'h0007 || freq_source_select == FSRC_CALC; endproperty
  a_codes: assert property (p_codes) else $error("bad source code held");
  property p_setp; setpoint_active == (freq_source_select == FSRC_SETPOINT); endproperty
  a_setp: assert property (p_setp) else $error("setpoint flag wrong");
  property p_sum; sum_inputs_en == (cmb == COMB_SUM_NO_REV || cmb == COMB_SUM_REV); endproperty
  a_sum: assert property (p_sum) else $error("sum flag wrong");
  property p_rev; reverse_sum_allowed == (cmb == COMB_SUM_REV); endproperty
  a_rev: assert property (p_rev) else $error("reverse flag wrong");
  property p_off; bipolar_voltage_input_off == (cmb == COMB_O2_OFF); endproperty
  a_off: assert property (p_off) else $error("input off flag wrong");
  property p_max; max_freq_motor1 >= FREQ_MIN_HZ && max_freq_motor1 <= FREQ_MAX_HZ; endproperty
  a_max: assert property (p_max) else $error("max out of range");
  property p_base; base_freq_motor1 >= FREQ_MIN_HZ && base_freq_motor1 <= max_freq_motor1; endproperty
  a_base: assert property (p_base) else $error("base out of range");
  property p_resv;
    s_done ##0 (paddr[15:2] inside {[14'h2205:14'h2215], [14'h3205:14'h3215]}) |-> pslverr;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved access accepted");
endmodule : drsc_regs_properties

`default_nettype wire

// >>> tb/drsc_apb_mst.sv
// Purpose: network master model driving the register bank over apb
// Assumes: called right after reset release, from one process only
// Notes:   released lines show inverted data, never the last request
`default_nettype none

module drsc_apb_mst
  import drsc_pkg::*;
(
  // clock
  input  wire logic              pclk,
  // request
  output var  logic              psel,
  output var  logic              penable,
  output var  logic              pwrite,
  output var  logic [ADDR_W-1:0] paddr,
  output var  logic [31:0]       pwdata,
  // answer
  input  wire logic              pready,
  input  wire logic [31:0]       prdata,
  input  wire logic              pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
  end
  // leading edge keeps a release and the next setup in different steps
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= ~w;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : drsc_apb_mst

`default_nettype wire

// >>> tb/tb.sv
// Purpose: self-checking bench for the drive source register bank
// Assumes: one wait state per access, settings update at commit
// Notes:   expected values come from the documented ranges
`default_nettype none

module tb
  import drsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0]   paddr;
  logic [31:0]         pwdata, prdata;
  logic [DATA_W-1:0]   freq_source_select, bipolar_input_combine;
  logic [DATA_W-1:0]   max_freq_motor3, base_freq_motor2;
  logic [DATA_W-1:0]   base_freq_motor1, max_freq_motor1, max_freq_motor2, base_freq_motor3;
  logic [DATA_W-1:0]   run_source_select, analog_toggle_select;
  logic                sum_inputs_en, reverse_sum_allowed, bipolar_voltage_input_off;
  logic                setpoint_active;
  logic [2*DATA_W-1:0] stored_target_frequency;
  int                  fails, checks_done;
  localparam logic [IDX_W-1:0] RI [10] = '{IDX_FREQ_SRC, IDX_RUN_SRC, IDX_BASE_M1,
    IDX_MAX_M1, IDX_TOGGLE_SEL, IDX_COMBINE, IDX_BASE_M2, IDX_MAX_M2, IDX_BASE_M3, IDX_MAX_M3};
  localparam logic [DATA_W-1:0] RV [10] = '{16'h0001, 16'h0001, 16'h003c, 16'h003c,
    16'h0000, 16'h0000, 16'h003c, 16'h003c, 16'h003c, 16'h003c};

  drsc_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .freq_source_select, .run_source_select, .analog_toggle_select,
    .bipolar_input_combine, .sum_inputs_en, .reverse_sum_allowed, .bipolar_voltage_input_off,
    .setpoint_active, .stored_target_frequency, .base_freq_motor1, .max_freq_motor1,
    .base_freq_motor2, .max_freq_motor2, .base_freq_motor3, .max_freq_motor3);
  drsc_apb_mst mst_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr);

  task automatic cmp(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : cmp

  task automatic acc(input logic w, input logic [IDX_W-1:0] i, input logic [31:0] d,
                     input logic e, input logic [DATA_W-1:0] v);
    logic [31:0] r;
    logic        er;
    mst_u.xfer(w, {i, 2'b00}, d, r, er);
    cmp(er === e, "error response");
    if (!w) cmp(r === {16'h0000, v}, "read data");
  endtask : acc

  task automatic wchk(input logic [IDX_W-1:0] i, input logic [31:0] d, input logic e,
                      input logic [DATA_W-1:0] v);
    acc(1'b1, i, d, e, 16'h0000);
    acc(1'b0, i, 32'h0000_0000, 1'b0, v);
  endtask : wchk

  // every code 0..15 written; ok marks the accepted ones
  task automatic sweep(input logic [IDX_W-1:0] i, input logic [15:0] ok,
                       input logic [DATA_W-1:0] v0);
    logic [DATA_W-1:0] last;
    last = v0;
    for (int c = 0; c < 16; c++) begin
      if (ok[c]) last = 16'(c);
      wchk(i, 32'(c), !ok[c], last);
      if (i == IDX_FREQ_SRC) cmp(freq_source_select === last, "source port");
      if (i == IDX_RUN_SRC) cmp(run_source_select === last, "run port");
      if (i == IDX_TOGGLE_SEL) cmp(analog_toggle_select === last, "toggle port");
      if (i == IDX_COMBINE) cmp(bipolar_input_combine === last, "combine port");
      if (i == IDX_FREQ_SRC)
        cmp(setpoint_active === (last == FSRC_SETPOINT), "setpoint flag");
      if (i == IDX_COMBINE)
        cmp({sum_inputs_en, reverse_sum_allowed, bipolar_voltage_input_off} === {last ==
          COMB_SUM_NO_REV || last == COMB_SUM_REV, last == COMB_SUM_REV, last == COMB_O2_OFF},
          "combine flags");
    end
  endtask : sweep

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    #100us;
    fails++;
    close_out();
  end

  initial begin
    logic [IDX_W-1:0] b;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 10; k++) acc(1'b0, RI[k], 32'h0, 1'b0, RV[k]);
    sweep(IDX_FREQ_SRC, 16'h04ff, 16'h0001);
    sweep(IDX_RUN_SRC, 16'h003e, 16'h0001);
    sweep(IDX_TOGGLE_SEL, 16'h001f, 16'h0000);
    sweep(IDX_COMBINE, 16'h000f, 16'h0000);
    for (int m = 0; m < MOTORS; m++) begin
      b = IDX_W'(IDX_BASE_M1 + m * IDX_MOTOR_STEP);
      wchk(b + 14'h0001, 32'h0000_0191, 1'b1, 16'h003c);
      wchk(b + 14'h0001, 32'h0000_0190, 1'b0, 16'h0190);
      wchk(b, 32'h0000_001d, 1'b1, 16'h003c);
      wchk(b, 32'h0000_0190, 1'b0, 16'h0190);
      wchk(b, 32'h0000_0191, 1'b1, 16'h0190);
      wchk(b + 14'h0001, 32'h0000_018f, 1'b1, 16'h0190);
      wchk(b, 32'h0000_001e, 1'b0, 16'h001e);
      wchk(b + 14'h0001, 32'h0000_001e, 1'b0, 16'h001e);
      wchk(b + 14'h0001, 32'h0000_001d, 1'b1, 16'h001e);
    end
    cmp(max_freq_motor3 === 16'h001e && base_freq_motor2 === 16'h001e, "motor ports");
    cmp(base_freq_motor1 === 16'h001e && base_freq_motor3 === 16'h001e, "base ports");
    cmp(max_freq_motor1 === 16'h001e && max_freq_motor2 === 16'h001e, "max ports");
    acc(1'b1, 14'h2205, 32'h0000_001e, 1'b1, 16'h0000);
    acc(1'b0, 14'h3215, 32'h0000_0000, 1'b1, 16'h0000);
    wchk(IDX_SETPOINT_LO, 32'h0000_9c40, 1'b0, 16'h9c40);
    wchk(IDX_SETPOINT_HI, 32'h0000_0001, 1'b1, 16'h0000);
    wchk(IDX_SETPOINT_LO, 32'h0000_9c41, 1'b1, 16'h9c40);
    acc(1'b0, IDX_STATUS, 32'h0000_0000, 1'b0, 16'h0001);
    wchk(IDX_STATUS, 32'h0000_0002, 1'b1, 16'h0001);
    cmp(stored_target_frequency === 32'h0000_9c40, "setpoint port");
    close_out();
  end
endmodule : tb

bind drsc_regs drsc_regs_properties chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .freq_source_select, .bipolar_input_combine,
  .sum_inputs_en, .reverse_sum_allowed, .bipolar_voltage_input_off, .setpoint_active,
  .base_freq_motor1, .max_freq_motor1);

`default_nettype wire
